// file: verilog/wdt_top.v
// Watchdog timer: 18-bit counter on watchdog clock ticks, time-out,
// reset delay, system reset pulse, wake-up request, Avalon-MM registers.
// Assumes clk_sys is an always-on clock much faster than the watchdog
// clock, and that rst_n is not driven from this block's own reset output.
`timescale 1ns/10ps
`include "wdt_consts.vh"

module wdt_top (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// Watchdog clock pin
	input  wire        watchdogClock,
	// Clock and power state from the system controller
	input  wire        clkSrcLirc,
	input  wire        clkSrcLxt,
	input  wire        idleMode,
	input  wire        powerDown,
	// Boot configuration
	input  wire [31:0] bootConfigWord0,
	// Avalon-MM slave
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// System outputs
	output reg         sysResetReq,
	output reg         wakeReq,
	output reg         irq
);

	// ****************************************
	// States
	// ****************************************
	localparam [2:0] ST_RUN = 3'h1;
	localparam [2:0] ST_DLY = 3'h2;
	localparam [2:0] ST_RST = 3'h4;
	localparam [11:0] CTRL_RST = `WDT_CTRL_RESET;

	// ****************************************
	// Functions
	// ****************************************
	// True when the next tick brings the count to a multiple of 2^exponent
	function wdtIsTimeout;
		input [`WDT_CNT_W-1:0] cnt;
		input [3:0]            sel;
		reg   [4:0]            expo;
		reg   [`WDT_CNT_W-1:0] mask;
		begin
			expo = (sel > `WDT_ISEL_MAX) ? `WDT_EXP_MAX : ({1'b0, sel} + `WDT_EXP_MIN);
			mask = ({{(`WDT_CNT_W-1){1'b0}}, 1'b1} << expo) - {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
			wdtIsTimeout = ((cnt & mask) == mask);
		end
	endfunction

	function [`WDT_DLY_W-1:0] wdtDelayLimit;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: wdtDelayLimit = `WDT_DLY_SEL0;
				2'h1: wdtDelayLimit = `WDT_DLY_SEL1;
				2'h2: wdtDelayLimit = `WDT_DLY_SEL2;
				default: wdtDelayLimit = `WDT_DLY_SEL3;
			endcase
		end
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	wire                   wdClkSync;
	reg                    wdClkPrev_r;
	wire                   wdTick;
	wire                   tickOk;
	reg                    bootSeen_r;
	reg                    forceEn_r;
	reg                    ctrlEn_r;
	reg  [3:0]             ctrlIsel_r;
	reg  [1:0]             ctrlDsel_r;
	reg                    ctrlRstEn_r;
	reg                    ctrlWakeEn_r;
	reg  [`WDT_EVT_W-1:0]  evtStat_r;
	reg  [`WDT_EVT_W-1:0]  evtStat_nxt;
	reg  [`WDT_EVT_W-1:0]  intEn_r;
	wire [`WDT_EVT_W-1:0]  intEnNow;
	reg  [2:0]             state_r;
	reg  [2:0]             state_nxt;
	reg  [`WDT_CNT_W-1:0]  cnt_r;
	reg  [`WDT_CNT_W-1:0]  cnt_nxt;
	reg  [`WDT_DLY_W-1:0]  dlyCnt_r;
	reg  [`WDT_DLY_W-1:0]  dlyCnt_nxt;
	reg  [`WDT_RST_W-1:0]  rstCnt_r;
	reg  [`WDT_RST_W-1:0]  rstCnt_nxt;
	wire                   wdOn;
	wire                   busTake;
	wire                   wrStb;
	wire                   clrPulse;
	wire                   timeoutEvt;
	wire                   resetEvt;
	wire                   wakeEvt;
	reg  [31:0]            rdMux;

	// ****************************************
	// Watchdog clock tick
	// ****************************************
	wdt_sync uSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.asyncIn (watchdogClock),
		.syncOut (wdClkSync)
	);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wdClkPrev_r <= 1'b0;
		end else begin
			wdClkPrev_r <= wdClkSync;
		end
	end

	// One tick per rising edge of the watchdog clock
	assign wdTick = wdClkSync & ~wdClkPrev_r;
	// Fast clocks stop in Power-down; only the low speed sources keep ticking
	assign tickOk = wdTick & (~powerDown | clkSrcLirc | clkSrcLxt);

	// ****************************************
	// Boot strap capture
	// ****************************************
	// Sampled once after reset release, never through the reset itself
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bootSeen_r <= 1'b0;
			forceEn_r  <= 1'b0;
		end else if (!bootSeen_r) begin
			bootSeen_r <= 1'b1;
			forceEn_r  <= ~bootConfigWord0[`WDT_BOOT_FORCE_EN_N_BIT];
		end
	end

	// Forced mode overrides the software enable, so software cannot stop it
	assign wdOn = ctrlEn_r | forceEn_r;

	// ****************************************
	// Bus slave
	// ****************************************
	// Request is acknowledged one cycle after it is seen; a write takes
	// effect at the edge where waitrequest is sampled low
	assign busTake  = (avs_read | avs_write) & avs_waitrequest;
	assign wrStb    = avs_write & ~avs_waitrequest;
	assign clrPulse = wrStb & (avs_address == `WDT_OFS_CTRL) &
	                  avs_writedata[`WDT_CTRL_CLR_BIT];

	always @* begin
		rdMux = 32'h0000_0000;
		case (avs_address)
			`WDT_OFS_CTRL: begin
				rdMux[`WDT_CTRL_EN_BIT]                       = ctrlEn_r;
				rdMux[`WDT_CTRL_ISEL_HI:`WDT_CTRL_ISEL_LO]    = ctrlIsel_r;
				rdMux[`WDT_CTRL_DSEL_HI:`WDT_CTRL_DSEL_LO]    = ctrlDsel_r;
				rdMux[`WDT_CTRL_RSTEN_BIT]                    = ctrlRstEn_r;
				rdMux[`WDT_CTRL_WAKEEN_BIT]                   = ctrlWakeEn_r;
			end
			`WDT_OFS_STATUS: begin
				rdMux[`WDT_EVT_W-1:0]       = evtStat_r;
				rdMux[`WDT_STAT_ON_BIT]     = wdOn;
				rdMux[`WDT_STAT_FORCE_BIT]  = forceEn_r;
			end
			`WDT_OFS_INT_EN: rdMux[`WDT_EVT_W-1:0] = intEn_r;
			`WDT_OFS_COUNT:  rdMux[`WDT_CNT_W-1:0] = cnt_r;
			default:         rdMux = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (busTake) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rdMux : 32'h0000_0000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrlEn_r     <= CTRL_RST[`WDT_CTRL_EN_BIT];
			ctrlIsel_r   <= CTRL_RST[`WDT_CTRL_ISEL_HI:`WDT_CTRL_ISEL_LO];
			ctrlDsel_r   <= CTRL_RST[`WDT_CTRL_DSEL_HI:`WDT_CTRL_DSEL_LO];
			ctrlRstEn_r  <= CTRL_RST[`WDT_CTRL_RSTEN_BIT];
			ctrlWakeEn_r <= CTRL_RST[`WDT_CTRL_WAKEEN_BIT];
			intEn_r      <= `WDT_EVT_RESET_VAL;
		end else if (wrStb) begin
			if (avs_address == `WDT_OFS_CTRL) begin
				ctrlEn_r     <= avs_writedata[`WDT_CTRL_EN_BIT];
				ctrlIsel_r   <= avs_writedata[`WDT_CTRL_ISEL_HI:`WDT_CTRL_ISEL_LO];
				ctrlDsel_r   <= avs_writedata[`WDT_CTRL_DSEL_HI:`WDT_CTRL_DSEL_LO];
				ctrlRstEn_r  <= avs_writedata[`WDT_CTRL_RSTEN_BIT];
				ctrlWakeEn_r <= avs_writedata[`WDT_CTRL_WAKEEN_BIT];
			end
			if (avs_address == `WDT_OFS_INT_EN) begin
				intEn_r <= avs_writedata[`WDT_EVT_W-1:0];
			end
		end
	end

	// ****************************************
	// Watchdog sequence
	// ****************************************
	assign timeoutEvt = tickOk & wdOn & (state_r == ST_RUN) &
	                    wdtIsTimeout(cnt_r, ctrlIsel_r);
	assign resetEvt   = (state_r == ST_DLY) & (state_nxt == ST_RST);
	// Only clkSrcLirc can raise wake, though clkSrcLxt also ticks in both low power modes
	assign wakeEvt    = timeoutEvt & ctrlWakeEn_r & clkSrcLirc &
	                    (idleMode | powerDown);

	always @* begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		dlyCnt_nxt = dlyCnt_r;
		rstCnt_nxt = rstCnt_r;
		case (state_r)
			ST_RUN: begin
				dlyCnt_nxt = {`WDT_DLY_W{1'b0}};
				rstCnt_nxt = {`WDT_RST_W{1'b0}};
				if (!wdOn || clrPulse) begin
					cnt_nxt = {`WDT_CNT_W{1'b0}};
				end else if (tickOk) begin
					cnt_nxt = cnt_r + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
					if (timeoutEvt && ctrlRstEn_r) begin
						state_nxt = ST_DLY;
					end
				end
			end
			ST_DLY: begin
				if (!wdOn || clrPulse) begin
					// Servicing in time cancels the pending reset
					state_nxt  = ST_RUN;
					cnt_nxt    = {`WDT_CNT_W{1'b0}};
					dlyCnt_nxt = {`WDT_DLY_W{1'b0}};
				end else if (tickOk) begin
					cnt_nxt = cnt_r + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
					if (dlyCnt_r == wdtDelayLimit(ctrlDsel_r) - {{(`WDT_DLY_W-1){1'b0}}, 1'b1}) begin
						state_nxt  = ST_RST;
						dlyCnt_nxt = {`WDT_DLY_W{1'b0}};
					end else begin
						dlyCnt_nxt = dlyCnt_r + {{(`WDT_DLY_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_RST: begin
				cnt_nxt = {`WDT_CNT_W{1'b0}};
				if (tickOk) begin
					if (rstCnt_r == `WDT_RST_PERIODS - {{(`WDT_RST_W-1){1'b0}}, 1'b1}) begin
						state_nxt  = ST_RUN;
						rstCnt_nxt = {`WDT_RST_W{1'b0}};
					end else begin
						rstCnt_nxt = rstCnt_r + {{(`WDT_RST_W-1){1'b0}}, 1'b1};
					end
				end
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r  <= ST_RUN;
			cnt_r    <= {`WDT_CNT_W{1'b0}};
			dlyCnt_r <= {`WDT_DLY_W{1'b0}};
			rstCnt_r <= {`WDT_RST_W{1'b0}};
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			dlyCnt_r <= dlyCnt_nxt;
			rstCnt_r <= rstCnt_nxt;
		end
	end

	// ****************************************
	// Event flags and interrupt
	// ****************************************
	assign intEnNow = (wrStb && (avs_address == `WDT_OFS_INT_EN)) ?
	                  avs_writedata[`WDT_EVT_W-1:0] : intEn_r;

	always @* begin
		evtStat_nxt = evtStat_r;
		if (wrStb && (avs_address == `WDT_OFS_INT_CLR)) begin
			evtStat_nxt = evtStat_r & ~avs_writedata[`WDT_EVT_W-1:0];
		end
		// Set after clear, so an event in the clearing cycle survives
		evtStat_nxt[`WDT_EVT_TIMEOUT] = evtStat_nxt[`WDT_EVT_TIMEOUT] | timeoutEvt;
		evtStat_nxt[`WDT_EVT_RESET]   = evtStat_nxt[`WDT_EVT_RESET] | resetEvt;
		evtStat_nxt[`WDT_EVT_WAKE]    = evtStat_nxt[`WDT_EVT_WAKE] | wakeEvt;
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evtStat_r <= `WDT_EVT_RESET_VAL;
		end else begin
			evtStat_r <= evtStat_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sysResetReq <= 1'b0;
			wakeReq     <= 1'b0;
			irq         <= 1'b0;
		end else begin
			sysResetReq <= (state_nxt == ST_RST);
			// Wake stays up until software clears its flag
			wakeReq     <= evtStat_nxt[`WDT_EVT_WAKE];
			irq         <= |(evtStat_nxt & intEnNow);
		end
	end

endmodule

// file: pkg/wdt_consts.vh
// Constants of the watchdog block: register offsets, field positions,
// reset values and watchdog-clock period counts.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define WDT_ADDR_W          5
`define WDT_OFS_CTRL        5'h00
`define WDT_OFS_STATUS      5'h04
`define WDT_OFS_INT_EN      5'h08
`define WDT_OFS_INT_CLR     5'h0C
`define WDT_OFS_COUNT       5'h10

// ****************************************
// Control fields
// ****************************************
`define WDT_CTRL_EN_BIT     0
`define WDT_CTRL_ISEL_LO    4
`define WDT_CTRL_ISEL_HI    7
`define WDT_CTRL_DSEL_LO    8
`define WDT_CTRL_DSEL_HI    9
`define WDT_CTRL_RSTEN_BIT  10
`define WDT_CTRL_WAKEEN_BIT 11
`define WDT_CTRL_CLR_BIT    16
`define WDT_CTRL_RESET      12'h400

// ****************************************
// Status and interrupt fields
// ****************************************
`define WDT_EVT_W           3
`define WDT_EVT_TIMEOUT     0
`define WDT_EVT_RESET       1
`define WDT_EVT_WAKE        2
`define WDT_STAT_ON_BIT     8
`define WDT_STAT_FORCE_BIT  9
`define WDT_EVT_RESET_VAL   3'h0

// ****************************************
// Boot configuration
// ****************************************
`define WDT_BOOT_FORCE_EN_N_BIT 31

// ****************************************
// Counter and timing
// ****************************************
`define WDT_CNT_W           18
`define WDT_ISEL_MAX        4'hE
`define WDT_EXP_MIN         5'h04
`define WDT_EXP_MAX         5'h12
`define WDT_DLY_W           11
`define WDT_DLY_SEL0        11'h402
`define WDT_DLY_SEL1        11'h082
`define WDT_DLY_SEL2        11'h012
`define WDT_DLY_SEL3        11'h003
`define WDT_RST_W           6
`define WDT_RST_PERIODS     6'h3F

`endif

// file: verilog/wdt_sync.v
// Two-stage synchroniser for one level that comes from outside clk_sys.
// Assumes the input changes slower than clk_sys, as the watchdog clock does.
`timescale 1ns/10ps

module wdt_sync (
	// Clock and reset
	input  wire clk_sys,
	input  wire rst_n,
	// Level in and out
	input  wire asyncIn,
	output wire syncOut
);

	reg metaQ_r;
	reg syncQ_r;

	// First stage feeds only the second stage
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			metaQ_r <= 1'b0;
			syncQ_r <= 1'b0;
		end else begin
			metaQ_r <= asyncIn;
			syncQ_r <= metaQ_r;
		end
	end

	assign syncOut = syncQ_r;

endmodule

// file: test/wdt_properties.sv
// Checker bound to the watchdog top: bus handshake, reset pulse, irq, wake.
// Assumes a watchdog clock period of at least 8 clk_sys cycles.
`timescale 1ns/10ps
// ****
// Checker
// ****
module wdt_checker (
	// Clock and reset
	input wire        clk_sys,
	input wire        rst_n,
	// Inputs of the top
	input wire        watchdogClock,
	input wire        clkSrcLirc,
	input wire        idleMode,
	input wire        powerDown,
	input wire [4:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	// Outputs of the top
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        sysResetReq,
	input wire        wakeReq,
	input wire        irq
);
	reg        pin_r;
	reg [6:0]  rstTicks_r;
	reg [11:0] ctrl_r;
	wire       wrAck = avs_write && !avs_waitrequest;

	// Raw pin edges: the design sees each one a few cycles later
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_r <= 1'b0;
			rstTicks_r <= 7'h00;
			ctrl_r <= 12'h400;
		end else begin
			pin_r <= watchdogClock;
			if (!sysResetReq)
				rstTicks_r <= 7'h00;
			else if (watchdogClock && !pin_r)
				rstTicks_r <= rstTicks_r + 7'h01;
			if (wrAck && avs_address == 5'h00)
				ctrl_r <= avs_writedata[11:0];
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_ackOne; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_ackOne: assert property (p_ackOne) else $error("answer longer than one cycle");
	property p_readZero;
		avs_read && avs_waitrequest && (avs_address == 5'h0C || avs_address > 5'h10)
		|=> avs_readdata == 32'h0000_0000;
	endproperty
	a_readZero: assert property (p_readZero) else $error("empty place read nonzero");
	property p_rstLen; $fell(sysResetReq) |-> rstTicks_r == 7'h3F; endproperty
	a_rstLen: assert property (p_rstLen) else $error("reset pulse length wrong");
	property p_rstHold; sysResetReq && rstTicks_r < 7'h3F |=> sysResetReq; endproperty
	a_rstHold: assert property (p_rstHold) else $error("reset pulse ended early");
	property p_rstEn; $rose(sysResetReq) |-> ctrl_r[10]; endproperty
	a_rstEn: assert property (p_rstEn) else $error("reset while reset disabled");
	property p_irqFall; $fell(irq) |-> $past(wrAck && avs_address[4:3] == 2'b01); endproperty
	a_irqFall: assert property (p_irqFall) else $error("irq dropped unasked");
	property p_wakeSrc;
		$rose(wakeReq) |-> ctrl_r[11] && clkSrcLirc && (idleMode || powerDown);
	endproperty
	a_wakeSrc: assert property (p_wakeSrc) else $error("wake from wrong source");
endmodule

bind wdt_top wdt_checker chk (.clk_sys, .rst_n, .watchdogClock, .clkSrcLirc, .idleMode,
	.powerDown, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .sysResetReq, .wakeReq, .irq);

// file: test/wdt_partner.sv
// Low speed oscillator model that clocks the watchdog.
// Assumes clk_sys at 200 MHz; the pin toggles every 4 cycles while run is high.
`timescale 1ns/10ps
module wdt_partner (
	// Clock and reset
	input wire  clk_sys,
	input wire  rst_n,
	// Oscillator gate from the bench
	input wire  run,
	// Oscillator pin
	output reg  watchdogClock
);
	reg [1:0] phase_r;

	// Runs through Power-down too; stands still only while run is low
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 2'h0;
			watchdogClock <= 1'b0;
		end else if (run) begin
			phase_r <= phase_r + 2'h1;
			if (phase_r == 2'h3)
				watchdogClock <= !watchdogClock;
		end
	end
endmodule

// file: test/watchdog_timeout_reset_test.sv
// Testbench for the watchdog top: time-out, delay, reset pulse, irq, wake.
// Assumes the partner oscillator gives one tick per 8 clk_sys cycles.
`timescale 1ns/10ps
`include "wdt_consts.vh"
module watchdog_timeout_reset_test;
	reg         clk_sys = 1'b0;
	reg         rst_n = 1'b0;
	reg         run = 1'b0;
	reg         clkSrcLirc = 1'b0;
	reg         clkSrcLxt = 1'b0;
	reg         idleMode = 1'b0;
	reg         powerDown = 1'b0;
	reg  [31:0] bootConfigWord0 = 32'h8000_0000;
	reg  [4:0]  avs_address = 5'h00;
	reg         avs_read = 1'b0;
	reg         avs_write = 1'b0;
	reg  [31:0] avs_writedata = 32'h0000_0000;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire        sysResetReq;
	wire        wakeReq;
	wire        irq;
	wire        watchdogClock;
	int         errors = 0;
	int         checked = 0;
	int         ticks = 0;
	int         dt;
	// Interval select, delay select, ticks to time-out, ticks to reset
	int         rows[4][4] = '{'{0, 0, 16, 1026}, '{1, 1, 32, 130}, '{2, 2, 64, 18},
		'{3, 3, 128, 3}};

	always #2.5 clk_sys = !clk_sys;
	always @(posedge watchdogClock) ticks++;

	wdt_partner osc (.clk_sys, .rst_n, .run, .watchdogClock);
	wdt_top uut (.clk_sys, .rst_n, .watchdogClock, .clkSrcLirc, .clkSrcLxt, .idleMode,
		.powerDown, .bootConfigWord0, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .sysResetReq, .wakeReq, .irq);

	task automatic check(input [31:0] seen, input [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Holds the request until waitrequest is sampled low, then one idle edge
	task automatic bus(input wr, input [4:0] a, input [31:0] d, output [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		check(avs_waitrequest, 32'h0000_0000, "waitrequest");
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input [4:0] a, input [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input [4:0] a, input [31:0] e, input string w);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(q, e, w);
	endtask

	task automatic idle;
		wr(`WDT_OFS_CTRL, 32'h0000_0000);
		wr(`WDT_OFS_INT_CLR, 32'h0000_0007);
	endtask

	task automatic waitT(input int n);
		int t0;
		t0 = ticks;
		while (ticks < t0 + n)
			@(posedge clk_sys);
	endtask

	// Stops the oscillator and lets the last tick cross the synchroniser
	task automatic halt;
		run <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic waitHi(input int w, output int dt);
		int t0;
		int n;
		t0 = ticks;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while ((w == 0 ? irq : w == 1 ? sysResetReq : w == 2 ? !sysResetReq : wakeReq)
			!== 1'b1 && n < 20000);
		dt = ticks - t0;
	endtask

	task automatic doReset(input [31:0] boot);
		rst_n <= 1'b0;
		bootConfigWord0 <= boot;
		repeat (12) @(posedge clk_sys);
		check(avs_waitrequest, 1, "waitrequest in reset");
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic conclude;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_sys);
		errors++;
		conclude();
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			idle();
			wr(`WDT_OFS_INT_EN, 32'h0000_0001);
			wr(`WDT_OFS_CTRL, 32'h0000_0401 | rows[i][0] << 4 | rows[i][1] << 8);
			run <= 1'b1;
			waitHi(0, dt);
			check(dt, rows[i][2], "interval");
			waitHi(1, dt);
			check(dt, rows[i][3], "delay");
			waitHi(2, dt);
			check(dt, 63, "reset length");
			run <= 1'b0;
			rd(`WDT_OFS_STATUS, 32'h0000_0103, "status");
			$display("row %0d done", i);
		end
		idle();
		wr(`WDT_OFS_INT_EN, 32'h0000_0000);
		wr(`WDT_OFS_CTRL, 32'h0000_0001);
		run <= 1'b1;
		waitT(20);
		halt();
		check(irq, 0, "masked irq");
		check(sysResetReq, 0, "no reset");
		rd(`WDT_OFS_STATUS, 32'h0000_0101, "status");
		wr(`WDT_OFS_INT_EN, 32'h0000_0001);
		check(irq, 1, "irq");
		wr(`WDT_OFS_INT_CLR, 32'h0000_0001);
		check(irq, 0, "cleared irq");
		rd(`WDT_OFS_STATUS, 32'h0000_0100, "status");
		$display("irq test done");
		idle();
		powerDown <= 1'b1;
		clkSrcLirc <= 1'b1;
		wr(`WDT_OFS_CTRL, 32'h0000_00E1);
		run <= 1'b1;
		waitT(20);
		halt();
		rd(`WDT_OFS_COUNT, 20, "count");
		clkSrcLirc <= 1'b0;
		run <= 1'b1;
		waitT(8);
		halt();
		rd(`WDT_OFS_COUNT, 20, "stopped count");
		$display("power-down test done");
		idle();
		powerDown <= 1'b0;
		clkSrcLirc <= 1'b1;
		idleMode <= 1'b1;
		wr(`WDT_OFS_CTRL, 32'h0000_0801);
		run <= 1'b1;
		waitHi(3, dt);
		check(dt, 16, "wake ticks");
		halt();
		rd(`WDT_OFS_STATUS, 32'h0000_0105, "wake status");
		idle();
		clkSrcLirc <= 1'b0;
		clkSrcLxt <= 1'b1;
		powerDown <= 1'b1;
		wr(`WDT_OFS_CTRL, 32'h0000_0801);
		run <= 1'b1;
		waitT(20);
		halt();
		check(wakeReq, 0, "crystal wake");
		rd(`WDT_OFS_STATUS, 32'h0000_0101, "crystal status");
		$display("wake test done");
		idle();
		powerDown <= 1'b0;
		clkSrcLxt <= 1'b0;
		idleMode <= 1'b0;
		wr(`WDT_OFS_CTRL, 32'h0000_0701);
		run <= 1'b1;
		repeat (4) begin
			waitT(10);
			wr(`WDT_OFS_CTRL, 32'h0001_0701);
		end
		halt();
		check(sysResetReq, 0, "serviced reset");
		rd(`WDT_OFS_STATUS, 32'h0000_0100, "serviced status");
		$display("service test done");
		doReset(32'h7FFF_FFFF);
		rd(`WDT_OFS_STATUS, 32'h0000_0300, "forced status");
		wr(`WDT_OFS_CTRL, 32'h0000_0000);
		run <= 1'b1;
		waitT(5);
		halt();
		rd(`WDT_OFS_COUNT, 5, "forced count");
		rd(`WDT_OFS_STATUS, 32'h0000_0300, "forced status");
		doReset(32'h8000_0000);
		rd(`WDT_OFS_CTRL, 32'h0000_0400, "ctrl reset");
		rd(`WDT_OFS_INT_EN, 32'h0000_0000, "int enable reset");
		rd(`WDT_OFS_INT_CLR, 32'h0000_0000, "int clear read");
		rd(5'h1C, 32'h0000_0000, "empty place");
		wr(`WDT_OFS_STATUS, 32'hFFFF_FFFF);
		rd(`WDT_OFS_STATUS, 32'h0000_0000, "status reset");
		$display("reset test done");
		conclude();
	end
endmodule
